/* File: rtl/hoc_gain_channel.sv */
// Purpose: Applied-gain tracker for one headphone channel.
// Assumes: Sample tick and zero-cross strobes come from logic on clk_i.
// Notes:   Reserved target codes are treated as the lowest legal code.

`timescale 1ns/1ps
`default_nettype none

module hoc_gain_channel
  import hoc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire hoc_ctrl_t  ctrl_i,
  input  wire logic [5:0] target_i,
  input  wire logic       sample_tick_i,
  input  wire logic       zero_cross_i,
  output var  logic [5:0] gain_o,
  output var  logic       busy_o
);

  logic [5:0] applied_ff;
  logic [5:0] gain_ff;
  logic [5:0] target;
  hoc_mode_t  mode;

  // Reserved codes would put the amplifier in an undefined state, so they clamp.
  assign target = (target_i < HOC_GAIN_MIN_CODE) ? HOC_GAIN_MIN_CODE : target_i;

  always_comb begin
    if (ctrl_i.ramp) begin
      mode = HOC_MODE_RAMP;
    end else if (ctrl_i.zero_cross) begin
      mode = HOC_MODE_ZERO_CROSS;
    end else begin
      mode = HOC_MODE_INSTANT;
    end
  end

  // ---------------------------------------------------------------------------
  // Applied gain
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      applied_ff <= HOC_GAIN_RESET;
    end else begin
      unique case (mode)
        HOC_MODE_INSTANT: begin
          applied_ff <= target;
        end
        HOC_MODE_ZERO_CROSS: begin
          if (zero_cross_i) begin
            applied_ff <= target;
          end
        end
        HOC_MODE_RAMP: begin
          if (sample_tick_i && (applied_ff < target)) begin
            applied_ff <= applied_ff + 6'h01;
          end else if (sample_tick_i && (applied_ff > target)) begin
            applied_ff <= applied_ff - 6'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_ff <= HOC_GAIN_RESET;
    end else begin
      gain_ff <= ctrl_i.min_hold ? HOC_GAIN_MIN_CODE : applied_ff;
    end
  end

  assign gain_o = gain_ff;
  assign busy_o = (applied_ff != target);

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_ramp_single_step: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == HOC_MODE_RAMP) && $past(mode == HOC_MODE_RAMP) && !$past(rst_i)
    |-> ((applied_ff == $past(applied_ff)) || (applied_ff == $past(applied_ff) + 6'h01)
         || (applied_ff == $past(applied_ff) - 6'h01)))
    else $error("ramp moved more than one code");

  a_ramp_needs_tick: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_i.ramp && !sample_tick_i) |=> $stable(applied_ff))
    else $error("ramp stepped without a sample tick");

  a_ramp_over_zc: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_i.ramp && ctrl_i.zero_cross && zero_cross_i && !sample_tick_i)
    |=> $stable(applied_ff))
    else $error("zero cross acted while ramping");

  a_zc_waits: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == HOC_MODE_ZERO_CROSS && !zero_cross_i) |=> $stable(applied_ff))
    else $error("gain changed before zero cross");

  a_instant_update: assert property (@(posedge clk_i) disable iff (rst_i)
    (mode == HOC_MODE_INSTANT) |=> (applied_ff == $past(target)))
    else $error("instant gain not applied");

  a_min_hold_out: assert property (@(posedge clk_i) disable iff (rst_i)
    ctrl_i.min_hold |=> (gain_o == HOC_GAIN_MIN_CODE))
    else $error("min gain hold not applied");

endmodule : hoc_gain_channel

`default_nettype wire

/* File: rtl/hoc_pkg.sv */
// Purpose: Shared constants, types and decode helpers for the headphone output control bank.
// Assumes: Classic Wishbone with 32-bit data, one register per aligned word.
// Notes:   Register indices are the printed offsets; the byte address is four times the index.

package hoc_pkg;

  // ---------------------------------------------------------------------------
  // Register indices
  // ---------------------------------------------------------------------------
  localparam logic [7:0] HOC_IDX_LEFT_CONTROL   = 8'hd0;
  localparam logic [7:0] HOC_IDX_LEFT_GAIN      = 8'hd1;
  localparam logic [7:0] HOC_IDX_RIGHT_CONTROL  = 8'hd2;
  localparam logic [7:0] HOC_IDX_RIGHT_GAIN     = 8'hd3;
  localparam logic [7:0] HOC_IDX_OUTPUT_SUPPLY  = 8'hd5;
  localparam logic [7:0] HOC_IDX_SUPPLY_KEY     = 8'hd7;

  // ---------------------------------------------------------------------------
  // Field positions and values
  // ---------------------------------------------------------------------------
  localparam int unsigned HOC_CTRL_FIELD_LSB     = 2;
  localparam int unsigned HOC_ENABLE_BIT         = 7;
  localparam int unsigned HOC_MUTE_BIT           = 6;
  localparam int unsigned HOC_RAMP_BIT           = 5;
  localparam int unsigned HOC_ZERO_CROSS_BIT     = 4;
  localparam int unsigned HOC_DRIVE_BIT          = 3;
  localparam int unsigned HOC_MIN_HOLD_BIT       = 2;
  localparam int unsigned HOC_SUPPLY_BIT         = 4;
  localparam int unsigned HOC_DIFF_BIT           = 0;
  localparam logic [7:0]  HOC_SUPPLY_KEY_VALUE   = 8'hc3;

  // Gain codes: one code per 1.5 dB, linear from the lowest legal code upward.
  localparam logic [5:0]  HOC_GAIN_MIN_CODE      = 6'h15;
  localparam logic [5:0]  HOC_GAIN_ZERO_DB_CODE  = 6'h3b;
  localparam logic [5:0]  HOC_GAIN_MAX_CODE      = 6'h3f;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  // Channel control field, six bits, bits 7 down to 2 of the control register.
  typedef struct packed {
    logic enable;
    logic mute;
    logic ramp;
    logic zero_cross;
    logic drive;
    logic min_hold;
  } hoc_ctrl_t;

  typedef enum logic [1:0] {
    HOC_MODE_INSTANT,
    HOC_MODE_ZERO_CROSS,
    HOC_MODE_RAMP
  } hoc_mode_t;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam hoc_ctrl_t   HOC_CTRL_RESET         = 6'h10;
  localparam logic [5:0]  HOC_GAIN_RESET         = HOC_GAIN_ZERO_DB_CODE;
  localparam logic        HOC_SUPPLY_RESET       = 1'b0;
  localparam logic        HOC_DIFF_RESET         = 1'b0;
  localparam logic        HOC_UNLOCK_RESET       = 1'b0;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic hoc_hit(input logic [31:0] adr, input logic [7:0] idx);
    hoc_hit = (adr[31:10] == 22'h00_0000) && (adr[9:2] == idx);
  endfunction : hoc_hit

  function automatic logic [7:0] hoc_ctrl_byte(input hoc_ctrl_t c);
    hoc_ctrl_byte = {c, 2'b00};
  endfunction : hoc_ctrl_byte

endpackage : hoc_pkg

/* File: rtl/hoc_top.sv */
// Purpose: Headphone output control bank behind a classic Wishbone slave.
// Assumes: One clock; audio sample tick and zero-cross strobes come from logic on clk_i.
// Notes:   Every access is answered one cycle after the request is seen, mapped or not.
//
// Function
// - Control bit 7 enables channel amplifier, resets off.
// - Control bit 6 mutes channel, reset muted.
// - Bit 5 ramps gain changes, else instant.
// - Bit 4 applies gain at zero crossing.
// - Ramping overrides zero-cross when both set.
// - Bit 3 drives output, else high impedance.
// - Bit 2 holds channel at minimum gain.
// - Six-bit gain code, low codes reserved.
// - Linear map, 1.5 dB per code.
// - Right gain resets to 0 dB code.
// - Supply bit 4 selects single supply.
// - Supply bit writable only after key write.
// - Right channel mirrors left, independently.
//
// Chosen here: register access over Wishbone.

`timescale 1ns/1ps
`default_nettype none

module hoc_top
  import hoc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  // Audio timing
  input  wire logic        sample_tick_i,
  input  wire logic        left_zero_cross_i,
  input  wire logic        right_zero_cross_i,
  // Amplifier controls
  output var  logic        left_amplifier_enable_o,
  output var  logic        left_amplifier_mute_o,
  output var  logic        left_output_drive_o,
  output var  logic [5:0]  left_gain_code_o,
  output var  logic        right_amplifier_enable_o,
  output var  logic        right_amplifier_mute_o,
  output var  logic        right_output_drive_o,
  output var  logic [5:0]  right_gain_code_o,
  output var  logic        single_supply_select_o,
  output var  logic        differential_output_select_o
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  hoc_ctrl_t   left_ctrl_ff;
  hoc_ctrl_t   right_ctrl_ff;
  logic [5:0]  left_gain_ff;
  logic [5:0]  right_gain_ff;
  logic        supply_ff;
  logic        diff_ff;
  logic        unlock_ff;
  logic        ack_ff;
  logic [31:0] dat_ff;
  logic [31:0] nxt_dat;
  logic        req;
  logic        wr_go;
  logic        left_busy;
  logic        right_busy;

  // ---------------------------------------------------------------------------
  // Bus handshake
  // ---------------------------------------------------------------------------
  assign req = wb_cyc_i && wb_stb_i;

  // The write lands on the edge at which the master sees ack, so a master that
  // drops the request early never half-writes a register.
  assign wr_go = req && wb_we_i && ack_ff && wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req && !ack_ff;
    end
  end

  always_comb begin
    nxt_dat = 32'h0000_0000;
    if (hoc_hit(wb_adr_i, HOC_IDX_LEFT_CONTROL)) begin
      nxt_dat[7:0] = hoc_ctrl_byte(left_ctrl_ff);
    end else if (hoc_hit(wb_adr_i, HOC_IDX_LEFT_GAIN)) begin
      nxt_dat[5:0] = left_gain_ff;
    end else if (hoc_hit(wb_adr_i, HOC_IDX_RIGHT_CONTROL)) begin
      nxt_dat[7:0] = hoc_ctrl_byte(right_ctrl_ff);
    end else if (hoc_hit(wb_adr_i, HOC_IDX_RIGHT_GAIN)) begin
      nxt_dat[5:0] = right_gain_ff;
    end else if (hoc_hit(wb_adr_i, HOC_IDX_OUTPUT_SUPPLY)) begin
      nxt_dat[HOC_SUPPLY_BIT] = supply_ff;
      nxt_dat[HOC_DIFF_BIT]   = diff_ff;
    end
  end

  // Read data is only valid alongside ack; it returns to zero otherwise.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_ff <= 32'h0000_0000;
    end else if (req && !ack_ff && !wb_we_i) begin
      dat_ff <= nxt_dat;
    end else begin
      dat_ff <= 32'h0000_0000;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;

  // ---------------------------------------------------------------------------
  // Channel registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      left_ctrl_ff <= HOC_CTRL_RESET;
    end else if (wr_go && hoc_hit(wb_adr_i, HOC_IDX_LEFT_CONTROL)) begin
      left_ctrl_ff <= wb_dat_i[7:HOC_CTRL_FIELD_LSB];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      right_ctrl_ff <= HOC_CTRL_RESET;
    end else if (wr_go && hoc_hit(wb_adr_i, HOC_IDX_RIGHT_CONTROL)) begin
      right_ctrl_ff <= wb_dat_i[7:HOC_CTRL_FIELD_LSB];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      left_gain_ff <= HOC_GAIN_RESET;
    end else if (wr_go && hoc_hit(wb_adr_i, HOC_IDX_LEFT_GAIN)) begin
      left_gain_ff <= wb_dat_i[5:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      right_gain_ff <= HOC_GAIN_RESET;
    end else if (wr_go && hoc_hit(wb_adr_i, HOC_IDX_RIGHT_GAIN)) begin
      right_gain_ff <= wb_dat_i[5:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Supply mode and key
  // ---------------------------------------------------------------------------
  // The key opens one write to the supply register; any later write needs a
  // fresh key, so a stray write can never flip the supply mode.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unlock_ff <= HOC_UNLOCK_RESET;
    end else if (wr_go && hoc_hit(wb_adr_i, HOC_IDX_SUPPLY_KEY)) begin
      unlock_ff <= (wb_dat_i[7:0] == HOC_SUPPLY_KEY_VALUE);
    end else if (wr_go && hoc_hit(wb_adr_i, HOC_IDX_OUTPUT_SUPPLY)) begin
      unlock_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      supply_ff <= HOC_SUPPLY_RESET;
    end else if (wr_go && hoc_hit(wb_adr_i, HOC_IDX_OUTPUT_SUPPLY) && unlock_ff) begin
      supply_ff <= wb_dat_i[HOC_SUPPLY_BIT];
    end
  end

  // Zero here is a reserved setting; it is stored as written and left to software.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      diff_ff <= HOC_DIFF_RESET;
    end else if (wr_go && hoc_hit(wb_adr_i, HOC_IDX_OUTPUT_SUPPLY)) begin
      diff_ff <= wb_dat_i[HOC_DIFF_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Gain trackers
  // ---------------------------------------------------------------------------
  hoc_gain_channel u_left (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .ctrl_i        (left_ctrl_ff),
    .target_i      (left_gain_ff),
    .sample_tick_i (sample_tick_i),
    .zero_cross_i  (left_zero_cross_i),
    .gain_o        (left_gain_code_o),
    .busy_o        (left_busy)
  );

  hoc_gain_channel u_right (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .ctrl_i        (right_ctrl_ff),
    .target_i      (right_gain_ff),
    .sample_tick_i (sample_tick_i),
    .zero_cross_i  (right_zero_cross_i),
    .gain_o        (right_gain_code_o),
    .busy_o        (right_busy)
  );

  // ---------------------------------------------------------------------------
  // Amplifier outputs
  // ---------------------------------------------------------------------------
  assign left_amplifier_enable_o      = left_ctrl_ff.enable;
  assign left_amplifier_mute_o        = left_ctrl_ff.mute;
  assign left_output_drive_o          = left_ctrl_ff.drive;
  assign right_amplifier_enable_o     = right_ctrl_ff.enable;
  assign right_amplifier_mute_o       = right_ctrl_ff.mute;
  assign right_output_drive_o         = right_ctrl_ff.drive;
  assign single_supply_select_o       = supply_ff;
  assign differential_output_select_o = diff_ff;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  a_ack_follows_req: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_ack_o) |=> wb_ack_o)
    else $error("request not answered in one cycle");

  a_ctrl_reset_state: assert property (@(posedge clk_i)
    $past(rst_i) |-> (!left_amplifier_enable_o && left_amplifier_mute_o
                      && !right_amplifier_enable_o && right_amplifier_mute_o
                      && !left_output_drive_o && !right_output_drive_o))
    else $error("control reset state wrong");

  a_ctrl_write_left: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_go && hoc_hit(wb_adr_i, HOC_IDX_LEFT_CONTROL))
    |=> (left_amplifier_enable_o == $past(wb_dat_i[HOC_ENABLE_BIT]))
        && (left_amplifier_mute_o == $past(wb_dat_i[HOC_MUTE_BIT]))
        && (left_output_drive_o == $past(wb_dat_i[HOC_DRIVE_BIT])))
    else $error("left control write not applied");

  a_right_independent: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_go && !hoc_hit(wb_adr_i, HOC_IDX_RIGHT_CONTROL)) |=> $stable(right_ctrl_ff))
    else $error("right control changed by another write");

  a_drive_right: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_go && hoc_hit(wb_adr_i, HOC_IDX_RIGHT_CONTROL))
    |=> (right_output_drive_o == $past(wb_dat_i[HOC_DRIVE_BIT])))
    else $error("right output drive not applied");

  a_supply_locked: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_go && hoc_hit(wb_adr_i, HOC_IDX_OUTPUT_SUPPLY) && !unlock_ff)
    |=> $stable(single_supply_select_o))
    else $error("supply mode changed without key");

  a_supply_unlocked: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_go && hoc_hit(wb_adr_i, HOC_IDX_OUTPUT_SUPPLY) && unlock_ff)
    |=> (single_supply_select_o == $past(wb_dat_i[HOC_SUPPLY_BIT])) && !unlock_ff)
    else $error("unlocked supply write not applied once");

  a_gain_reset: assert property (@(posedge clk_i)
    $past(rst_i) |-> (right_gain_ff == HOC_GAIN_ZERO_DB_CODE)
                     && (left_gain_ff == HOC_GAIN_ZERO_DB_CODE))
    else $error("gain reset code wrong");

  a_gain_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    (req && !wb_ack_o && !wb_we_i && hoc_hit(wb_adr_i, HOC_IDX_RIGHT_GAIN))
    |=> (wb_dat_o == {26'h000_0000, right_gain_ff}))
    else $error("gain readback wrong");

  // Once a tracker has settled on a legal code with min hold clear, the pin shows that code one cycle later.
  a_left_settled: assert property (@(posedge clk_i) disable iff (rst_i)
    (!left_busy && !left_ctrl_ff.min_hold && (left_gain_ff >= HOC_GAIN_MIN_CODE))
    |=> (left_gain_code_o == $past(left_gain_ff)))
    else $error("left gain code not applied");

  a_right_settled: assert property (@(posedge clk_i) disable iff (rst_i)
    (!right_busy && !right_ctrl_ff.min_hold && (right_gain_ff >= HOC_GAIN_MIN_CODE))
    |=> (right_gain_code_o == $past(right_gain_ff)))
    else $error("right gain code not applied");

  // Only the exact key value may open the supply bit; anything else leaves it shut.
  a_key_opens: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_go && hoc_hit(wb_adr_i, HOC_IDX_SUPPLY_KEY))
    |=> (unlock_ff == ($past(wb_dat_i[7:0]) == HOC_SUPPLY_KEY_VALUE)))
    else $error("supply key not decoded");

endmodule : hoc_top

`default_nettype wire

/* File: verif/headphone_output_control_tb.sv */
// Purpose: Self-checking bench for the headphone output control bank.
// Assumes: Wishbone answers one cycle after a request; gain outputs settle within three cycles.
// Notes:   Read expectations are queued by the driver and checked by a watcher on ack.

`timescale 1ns/1ps
`default_nettype none

module headphone_output_control_tb;
  import hoc_pkg::*;

  // ---------------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------------
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [31:0] wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        sample_tick_i;
  logic        left_zero_cross_i;
  logic        right_zero_cross_i;
  logic        l_en, l_mute, l_drive, r_en, r_mute, r_drive, single_o, diff_o;
  logic [5:0]  l_gain, r_gain;
  logic [31:0] exp_q[$];
  int          miscompares;
  int          comparisons;
  integer      seed;
  logic [31:0] rnd;

  hoc_top dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sample_tick_i(sample_tick_i),
    .left_zero_cross_i(left_zero_cross_i), .right_zero_cross_i(right_zero_cross_i),
    .left_amplifier_enable_o(l_en), .left_amplifier_mute_o(l_mute),
    .left_output_drive_o(l_drive), .left_gain_code_o(l_gain),
    .right_amplifier_enable_o(r_en), .right_amplifier_mute_o(r_mute),
    .right_output_drive_o(r_drive), .right_gain_code_o(r_gain),
    .single_supply_select_o(single_o), .differential_output_select_o(diff_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ---------------------------------------------------------------------------
  // Checking
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : print_verdict

  // Read data is taken only at the ack edge, where the request is still held.
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (exp_q.size() == 0) chk(wb_dat_o, 32'hdead_beef);
      else chk(wb_dat_o, exp_q.pop_front());
    end
  end

  function automatic logic [31:0] lch();
    lch = {23'h0, l_en, l_mute, l_drive, l_gain};
  endfunction : lch

  function automatic logic [31:0] rch();
    rch = {23'h0, r_en, r_mute, r_drive, r_gain};
  endfunction : rch

  // ---------------------------------------------------------------------------
  // Drivers
  // ---------------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc

  task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] d,
                     input logic [3:0] sel, input logic [7:0] exp);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {22'h00_0000, idx, 2'b00};
    wb_dat_i <= {24'h00_0000, d};
    wb_sel_i <= sel;
    if (!we) exp_q.push_back({24'h00_0000, exp});
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      miscompares++;
      $display("ERROR %0t: no ack", $time);
      print_verdict();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1'b1, idx, d, 4'h1, 8'h00);
  endtask : wr

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    bus(1'b0, idx, 8'h00, 4'h1, exp);
  endtask : rd

  // Pulses one audio strobe: 0 sample tick, 1 left zero cross, 2 right zero cross.
  task automatic pulse(input int which);
    @(posedge clk_i);
    if (which == 0) sample_tick_i <= 1'b1;
    if (which == 1) left_zero_cross_i <= 1'b1;
    if (which == 2) right_zero_cross_i <= 1'b1;
    @(posedge clk_i);
    sample_tick_i      <= 1'b0;
    left_zero_cross_i  <= 1'b0;
    right_zero_cross_i <= 1'b0;
    cyc(3);
  endtask : pulse

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    rst_i = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0;
    wb_adr_i = 32'h0000_0000; wb_dat_i = 32'h0000_0000; wb_sel_i = 4'h0;
    sample_tick_i = 1'b0; left_zero_cross_i = 1'b0; right_zero_cross_i = 1'b0;
    miscompares = 0; comparisons = 0; seed = 32'h4dae_95c1;
    cyc(10);
    rst_i <= 1'b0;
    cyc(2);
    chk(lch(), {23'h0, 3'b010, 6'h3b});
    chk(rch(), {23'h0, 3'b010, 6'h3b});
    chk({single_o, diff_o}, 32'h0000_0000);
    rd(8'hd0, 8'h40);
    rd(8'hd1, 8'h3b);
    rd(8'hd2, 8'h40);
    rd(8'hd3, 8'h3b);
    rd(8'hd5, 8'h00);
    rd(8'hd7, 8'h00);
    wr(8'hd0, 8'h88);
    cyc(3);
    chk(lch(), {23'h0, 3'b101, 6'h3b});
    chk(rch(), {23'h0, 3'b010, 6'h3b});
    wr(8'hd1, 8'h20);
    cyc(3);
    chk(lch(), {23'h0, 3'b101, 6'h20});
    wr(8'hd1, 8'hff);
    rd(8'hd1, 8'h3f);
    cyc(3);
    chk(lch(), {23'h0, 3'b101, 6'h3f});
    wr(8'hd0, 8'h8c);
    cyc(3);
    chk(lch(), {23'h0, 3'b101, 6'h15});
    rd(8'hd0, 8'h8c);
    wr(8'hd0, 8'h88);
    cyc(3);
    chk(lch(), {23'h0, 3'b101, 6'h3f});
    wr(8'hd2, 8'h10);
    wr(8'hd3, 8'h30);
    cyc(4);
    chk(rch(), {23'h0, 3'b000, 6'h3b});
    pulse(1);
    chk(rch(), {23'h0, 3'b000, 6'h3b});
    pulse(2);
    chk(rch(), {23'h0, 3'b000, 6'h30});
    wr(8'hd0, 8'hb8);
    wr(8'hd1, 8'h3c);
    pulse(1);
    chk(lch(), {23'h0, 3'b101, 6'h3f});
    for (int i = 1; i <= 4; i++) begin
      pulse(0);
      chk(lch(), {23'h0, 3'b101, (i < 4) ? 6'h3f - 6'(i) : 6'h3c});
    end
    wr(8'hd5, 8'h11);
    rd(8'hd5, 8'h01);
    wr(8'hd7, 8'hc3);
    wr(8'hd5, 8'h11);
    rd(8'hd5, 8'h11);
    cyc(2);
    chk({single_o, diff_o}, 32'h0000_0003);
    wr(8'hd5, 8'h01);
    rd(8'hd5, 8'h11);
    bus(1'b1, 8'hd2, 8'hff, 4'h0, 8'h00);
    rd(8'hd2, 8'h10);
    wr(8'hd4, 8'hff);
    rd(8'hd4, 8'h00);
    rd(8'hd6, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rnd = $random(seed);
      wr(8'hd2, rnd[7:0]);
      rd(8'hd2, {rnd[7:2], 2'b00});
      cyc(2);
      chk({r_en, r_mute, r_drive}, {29'h0, rnd[7], rnd[6], rnd[3]});
    end
    // A second reset in mid-run must bring written state back to its reset values.
    rst_i <= 1'b1;
    cyc(2);
    rst_i <= 1'b0;
    cyc(2);
    chk(lch(), {23'h0, 3'b010, 6'h3b});
    chk(rch(), {23'h0, 3'b010, 6'h3b});
    chk({single_o, diff_o}, 32'h0000_0000);
    cyc(3);
    print_verdict();
  end

endmodule : headphone_output_control_tb

`default_nettype wire
